// ===== src/mdm_data_mode_ctrl.sv
`timescale 1ns/1ps
`include "mdm_consts.svh"

// Function
// - Context activation command opens session, CONNECT
// - Dial string with id digit, answers CONNECT
// - After CONNECT, data mode, commands ignored
// - Data mode: received characters are payload, except a guarded escape and any that come while held pluses are still being forwarded
// - Data mode: unsolicited codes never sent
// - Unsolicited code in data mode toggles ring
// - Guarded escape returns command mode, answers OK
// - Online command resumes session, answers CONNECT
// - Hang-up OK comes within 20 seconds
module mdm_data_mode_ctrl
#(
  parameter int unsigned GUARD_CYC = `MDM_GUARD_CYC,
  parameter int unsigned HANG_CYC  = `MDM_HANG_CYC
)
(
  // Clock, reset, enable
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          clk_en,
  // Characters from the host
  input  wire logic [7:0]    rx_data,
  input  wire logic          rx_valid,
  // Characters to the host
  output logic      [7:0]    tx_data_q,
  output logic               tx_valid_q,
  input  wire logic          tx_ready,
  // Payload towards the packet server
  output logic      [7:0]    pay_data_q,
  output logic               pay_valid_q,
  // Network side events
  input  wire logic          urc_event,
  input  wire logic          urc_ack,
  input  wire logic          hangup_done,
  // Status
  output logic               urc_ring_indicator_q,
  output logic               urc_held_q,
  output logic               data_mode_q,
  output logic               session_q,
  output logic      [3:0]    context_identifier_q,
  output mdm_pkg::mdm_mode_type mode_q
);
  import mdm_pkg::*;

  // ****************************************************************
  // Command patterns
  // ****************************************************************
  function automatic logic [8*`MDM_PAT_MAX-1:0] pat_text(input int p);
    case (p)
      1:       pat_text = "AT+CGDATA=\"PPP\",@";
      2:       pat_text = "ATD*99***@#";
      3:       pat_text = "ATO";
      4:       pat_text = "ATH";
      5:       pat_text = "AT+CGDCONT?";
      default: pat_text = "AT";
    endcase
  endfunction : pat_text

  function automatic logic [4:0] pat_len(input int p);
    case (p)
      1:       pat_len = 5'h11;
      2:       pat_len = 5'h0b;
      3:       pat_len = 5'h03;
      4:       pat_len = 5'h03;
      5:       pat_len = 5'h0b;
      default: pat_len = 5'h02;
    endcase
  endfunction : pat_len

  // Expected character i of pattern p; zero past the end
  function automatic logic [7:0] pat_char(input int p, input logic [4:0] i);
    logic [8*`MDM_PAT_MAX-1:0] t;
    t = pat_text(p);
    if (i >= pat_len(p))
      pat_char = `MDM_CHR_END;
    else
      pat_char = t[8*(int'(pat_len(p)) - 1 - int'(i)) +: 8];
  endfunction : pat_char

  // Commands are case-insensitive
  function automatic logic [7:0] upper(input logic [7:0] c);
    if (c >= 8'h61 && c <= 8'h7a)
      upper = c - 8'h20;
    else
      upper = c;
  endfunction : upper

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30) && (c <= 8'h39);
  endfunction : is_digit

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [5:0]  alive_q;      // Patterns still matching the line
  logic [4:0]  pos_q;        // Characters in the current line
  logic [3:0]  cand_cid_q;   // Digit caught at the wildcard
  logic [7:0]  rx_up;        // Upper-cased received character
  logic        line_done;    // Carriage return in command mode
  logic        hit_v;        // A complete pattern matched
  mdm_cmd_type hit_cmd;      // First complete match
  logic        act_start;    // Start a reply
  logic [5:0]  act_addr;     // Reply text start
  logic        act_go_data;  // Enter data mode after reply
  logic        act_hang;     // Enter hang-up wait
  logic        go_data_q;    // Data mode follows this reply
  logic [5:0]  rep_addr_q;   // Reply text pointer
  logic        rep_fetch_q;  // ROM byte is due this cycle
  logic        rep_wait_q;   // ROM still reading a new start
  logic [7:0]  rom_q;        // Reply text byte
  logic        reply_done;   // End byte reached
  logic [31:0] idle_q;       // Cycles since last received character
  logic        guard_ok;     // Line idle for the guard time
  logic [1:0]  held_q;       // Pluses held back as escape candidates
  logic [1:0]  flush_q;      // Held pluses still to forward
  logic [7:0]  pend_q;       // Character waiting behind a flush
  logic        pend_v_q;     // Waiting character is valid
  logic        esc_done;     // Guarded escape completed
  logic [31:0] hang_cnt_q;   // Hang-up wait counter
  logic        hang_end;     // Hang-up finished or timed out

  assign rx_up    = upper(rx_data);
  assign guard_ok = idle_q >= GUARD_CYC;
  assign line_done = rx_valid && mode_q == mode_cmd
                     && rx_up == `MDM_CHR_CR;
  assign reply_done = mode_q == mode_reply && rep_fetch_q
                      && rom_q == `MDM_CHR_END;
  assign esc_done = mode_q == mode_data && held_q == `MDM_ESC_COUNT
                    && guard_ok && !rx_valid;
  assign hang_end = mode_q == mode_hang
                    && (hangup_done || hang_cnt_q == HANG_CYC - 1);

  // ****************************************************************
  // Line parser
  // ****************************************************************
  // Each pattern is checked character by character, so no line
  // buffer is needed; a line longer than any pattern just fails
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      alive_q    <= '1;
      pos_q      <= '0;
      cand_cid_q <= `MDM_CID_RESET;
    end
    else if (clk_en)
    begin
      if (line_done || mode_q != mode_cmd)
      begin
        alive_q <= '1;
        pos_q   <= '0;
      end
      else if (rx_valid && rx_up != `MDM_CHR_LF)
      begin
        for (int p = 0; p < `MDM_NUM_CMD; p++)
        begin
          if (pat_char(p, pos_q) == `MDM_CHR_WILD)
          begin
            alive_q[p] <= alive_q[p] && is_digit(rx_up);
            if (alive_q[p])
              cand_cid_q <= rx_up[3:0];
          end
          else
            alive_q[p] <= alive_q[p] && pat_char(p, pos_q) == rx_up;
        end
        if (pos_q != 5'h1f)
          pos_q <= pos_q + 5'h01;
      end
    end
  end

  // First pattern that is alive and complete wins
  always_comb
  begin
    hit_v   = 1'b0;
    hit_cmd = cmd_at;
    for (int p = `MDM_NUM_CMD - 1; p >= 0; p--)
    begin
      if (alive_q[p] && pos_q == pat_len(p))
      begin
        hit_v   = 1'b1;
        hit_cmd = mdm_cmd_type'(3'(p));
      end
    end
  end

  // ****************************************************************
  // Action decode
  // ****************************************************************
  always_comb
  begin
    act_start   = 1'b0;
    act_addr    = `MDM_ROM_OK;
    act_go_data = 1'b0;
    act_hang    = 1'b0;
    if (line_done && hit_v)
    begin
      act_start = 1'b1;
      case (hit_cmd)
        cmd_cgdata, cmd_dial:
        begin
          act_addr    = session_q ? `MDM_ROM_ERROR : `MDM_ROM_CONNECT;
          act_go_data = !session_q;
        end
        cmd_online:
        begin
          act_addr    = session_q ? `MDM_ROM_CONNECT : `MDM_ROM_ERROR;
          act_go_data = session_q;
        end
        cmd_hangup:
        begin
          // a live session waits for release first
          act_start = !session_q;
          act_hang  = session_q;
        end
        cmd_query:
          act_addr = `MDM_ROM_QUERY;
        default:
          act_addr = `MDM_ROM_OK;
      endcase
    end
    else if (line_done && pos_q != 5'h00)
    begin
      // Unknown non-empty line
      act_start = 1'b1;
      act_addr  = `MDM_ROM_ERROR;
    end
    else if (esc_done || hang_end)
      act_start = 1'b1;
  end

  // ****************************************************************
  // Mode and session
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q               <= mode_cmd;
      go_data_q            <= 1'b0;
      data_mode_q          <= 1'b0;
      session_q            <= 1'b0;
      context_identifier_q <= `MDM_CID_RESET;
      hang_cnt_q           <= '0;
    end
    else if (clk_en)
    begin
      case (mode_q)
        mode_cmd:
        begin
          hang_cnt_q <= '0;
          if (act_hang)
            mode_q <= mode_hang;
          else if (act_start)
          begin
            mode_q    <= mode_reply;
            go_data_q <= act_go_data;
            if (act_go_data && !session_q)
            begin
              session_q            <= 1'b1;
              context_identifier_q <= cand_cid_q;
            end
          end
        end
        mode_reply:
        begin
          if (reply_done)
          begin
            // data mode only once CONNECT is out
            mode_q      <= go_data_q ? mode_data : mode_cmd;
            data_mode_q <= go_data_q;
          end
        end
        mode_data:
        begin
          if (esc_done)
          begin
            mode_q      <= mode_reply;
            go_data_q   <= 1'b0;
            data_mode_q <= 1'b0;
          end
        end
        default:
        begin
          hang_cnt_q <= hang_cnt_q + 32'h1;
          if (hang_end)
          begin
            mode_q    <= mode_reply;
            go_data_q <= 1'b0;
            session_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Reply sender
  // ****************************************************************
  mdm_reply_rom u_rom
  (
    .clk    (clk),
    .clk_en (clk_en),
    .addr   (rep_addr_q),
    .data_q (rom_q)
  );

  // ROM answers one cycle after the pointer moves, hence the fetch
  // flag; a byte stays offered until the host side takes it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rep_addr_q  <= `MDM_ROM_OK;
      rep_fetch_q <= 1'b0;
      rep_wait_q  <= 1'b0;
      tx_valid_q  <= 1'b0;
      tx_data_q   <= '0;
    end
    else if (clk_en)
    begin
      if (act_start)
      begin
        // New start: the ROM register still holds the old byte,
        // so the first check must wait one more edge
        rep_addr_q <= act_addr;
        rep_wait_q <= 1'b1;
      end
      else if (rep_wait_q)
      begin
        rep_wait_q  <= 1'b0;
        rep_fetch_q <= 1'b1;
      end
      else if (tx_valid_q)
      begin
        if (tx_ready)
        begin
          tx_valid_q  <= 1'b0;
          rep_fetch_q <= 1'b1;
        end
      end
      else if (rep_fetch_q)
      begin
        rep_fetch_q <= 1'b0;
        if (rom_q != `MDM_CHR_END)
        begin
          tx_valid_q <= 1'b1;
          rep_addr_q <= rep_addr_q + 6'h01;
          if (rom_q == `MDM_CHR_CIDMARK)
            tx_data_q <= {4'h3, context_identifier_q};
          else
            tx_data_q <= rom_q;
        end
      end
    end
  end

  a_no_tx_data:
    assert property (@(posedge clk) disable iff (!rstn)
      mode_q == mode_data |-> !tx_valid_q)
    else $error("reply sent during data mode");

  a_connect_data:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reply_done && go_data_q |=> data_mode_q ##0
      mode_q == mode_data)
    else $error("no data mode after connect");

  // ****************************************************************
  // Data path and escape guard
  // ****************************************************************
  // Idle time counts on every enabled cycle, saturating at the guard
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      idle_q <= '0;
    else if (clk_en)
    begin
      if (rx_valid)
        idle_q <= '0;
      else if (!guard_ok)
        idle_q <= idle_q + 32'h1;
    end
  end

  // Pluses are held until the guard proves them an escape; a late
  // character releases them, one per cycle, ahead of itself
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      held_q      <= '0;
      flush_q     <= '0;
      pend_q      <= '0;
      pend_v_q    <= 1'b0;
      pay_valid_q <= 1'b0;
      pay_data_q  <= '0;
    end
    else if (clk_en)
    begin
      pay_valid_q <= 1'b0;
      if (esc_done)
        held_q <= '0;
      else if (mode_q == mode_data && rx_valid)
      begin
        if (rx_data == `MDM_CHR_PLUS
            && ((held_q == 2'h0 && guard_ok)
                || (held_q != 2'h0 && held_q != `MDM_ESC_COUNT)))
          held_q <= held_q + 2'h1;
        else if (held_q != 2'h0)
        begin
          flush_q  <= held_q;
          held_q   <= '0;
          pend_q   <= rx_data;
          pend_v_q <= 1'b1;
        end
        else
        begin
          pay_valid_q <= 1'b1;
          pay_data_q  <= rx_data;
        end
      end
      if (flush_q != 2'h0)
      begin
        pay_valid_q <= 1'b1;
        pay_data_q  <= `MDM_CHR_PLUS;
        flush_q     <= flush_q - 2'h1;
      end
      else if (pend_v_q)
      begin
        pay_valid_q <= 1'b1;
        pay_data_q  <= pend_q;
        pend_v_q    <= 1'b0;
      end
    end
  end

  a_rx_payload:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && mode_q == mode_data && rx_valid && held_q == 2'h0
      && rx_data != `MDM_CHR_PLUS && flush_q == 2'h0 && !pend_v_q
      |=> pay_valid_q && pay_data_q == $past(rx_data))
    else $error("data character not forwarded");

  a_unguarded_plus:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && mode_q == mode_data && rx_valid && held_q == 2'h0
      && !guard_ok |=> held_q == 2'h0)
    else $error("unguarded plus held back");

  a_escape_ok:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && esc_done |=> mode_q == mode_reply
      && rep_addr_q == `MDM_ROM_OK && !data_mode_q)
    else $error("escape did not answer ok");

  a_data_no_cmd:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && mode_q == mode_data && rx_valid |=>
      mode_q == mode_data)
    else $error("data character left data mode");

  a_hang_bound:
    assert property (@(posedge clk) disable iff (!rstn)
      mode_q == mode_hang |-> hang_cnt_q < HANG_CYC)
    else $error("hang-up wait overran");

  a_dial_cid:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && act_go_data && !session_q |=>
      session_q && context_identifier_q == $past(cand_cid_q))
    else $error("context id not taken");

  // ****************************************************************
  // Unsolicited code signalling
  // ****************************************************************
  // Code text is kept elsewhere; only its presence is flagged here
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      urc_ring_indicator_q <= 1'b0;
      urc_held_q           <= 1'b0;
    end
    else if (clk_en)
    begin
      if (urc_event && mode_q == mode_data)
      begin
        urc_ring_indicator_q <= !urc_ring_indicator_q;
        urc_held_q           <= 1'b1;
      end
      else if (urc_ack)
        urc_held_q <= 1'b0;
    end
  end

  a_ring_toggle:
    assert property (@(posedge clk) disable iff (!rstn)
      clk_en && urc_event && mode_q == mode_data |=>
      urc_ring_indicator_q != $past(urc_ring_indicator_q) && urc_held_q)
    else $error("ring line did not toggle");

endmodule : mdm_data_mode_ctrl

// ===== src/mdm_consts.svh
`ifndef MDM_CONSTS_SVH
`define MDM_CONSTS_SVH

// ******************************************************************
// Timing
// ******************************************************************
`define MDM_CLK_HZ      10000000
`define MDM_GUARD_MS    1000
`define MDM_HANG_MS     20000
// Least idle time: rounds down; 1 s is a whole number of cycles
`define MDM_GUARD_CYC   ((`MDM_CLK_HZ / 1000) * `MDM_GUARD_MS)
// Longest wait: rounds down; 20 s is a whole number of cycles
`define MDM_HANG_CYC    ((`MDM_CLK_HZ / 1000) * `MDM_HANG_MS)

// ******************************************************************
// Characters
// ******************************************************************
`define MDM_CHR_CR      8'h0d
`define MDM_CHR_LF      8'h0a
`define MDM_CHR_PLUS    8'h2b
`define MDM_CHR_WILD    8'h40
`define MDM_CHR_CIDMARK 8'h01
`define MDM_CHR_END     8'h00

// ******************************************************************
// Reply text layout and reset values
// ******************************************************************
`define MDM_ROM_CONNECT 6'h00
`define MDM_ROM_OK      6'h0a
`define MDM_ROM_ERROR   6'h0f
`define MDM_ROM_QUERY   6'h17
`define MDM_ROM_LAST    40
`define MDM_CID_RESET   4'h1
`define MDM_ESC_COUNT   2'h3
`define MDM_NUM_CMD     6
`define MDM_PAT_MAX     17

`endif

// ===== src/mdm_pkg.sv
package mdm_pkg;

  // Operating modes of the host port
  typedef enum logic [1:0] {
    mode_cmd,
    mode_reply,
    mode_data,
    mode_hang
  } mdm_mode_type;

  // Recognised command lines, in match priority order
  typedef enum logic [2:0] {
    cmd_at,
    cmd_cgdata,
    cmd_dial,
    cmd_online,
    cmd_hangup,
    cmd_query
  } mdm_cmd_type;

endpackage : mdm_pkg

// ===== src/mdm_reply_rom.sv
`timescale 1ns/1ps
`include "mdm_consts.svh"

// ******************************************************************
// Reply text store, registered read
// ******************************************************************
module mdm_reply_rom
(
  // Clock and enable
  input  wire logic       clk,
  input  wire logic       clk_en,
  // Read port
  input  wire logic [5:0] addr,
  output logic      [7:0] data_q
);

  // All replies end in a zero byte; the mark byte stands for the id
  localparam logic [8*41-1:0] text = {
    "CONNECT", `MDM_CHR_CR, `MDM_CHR_LF, `MDM_CHR_END,
    "OK", `MDM_CHR_CR, `MDM_CHR_LF, `MDM_CHR_END,
    "ERROR", `MDM_CHR_CR, `MDM_CHR_LF, `MDM_CHR_END,
    "+CGDCONT: ", `MDM_CHR_CIDMARK, `MDM_CHR_CR, `MDM_CHR_LF,
    "OK", `MDM_CHR_CR, `MDM_CHR_LF, `MDM_CHR_END};

  // Out-of-range reads give the end byte, so a stray walk stops
  always_ff @(posedge clk)
  begin
    if (clk_en)
    begin
      if (int'(addr) > `MDM_ROM_LAST)
        data_q <= `MDM_CHR_END;
      else
        data_q <= text[8*(`MDM_ROM_LAST - int'(addr)) +: 8];
    end
  end

endmodule : mdm_reply_rom

// ===== tb/mdm_host_model.sv
`timescale 1ns/1ps

// ******************************************************************
// Host controller model
// ******************************************************************
module mdm_host_model
#(
  parameter int unsigned GUARD_CYC = 20
)
(
  // Clock and pacing
  input  wire logic       clk,
  input  wire logic       slow,
  // Replies from the device
  input  wire logic [7:0] tx_data_q,
  input  wire logic       tx_valid_q,
  output logic            tx_ready,
  // Characters to the device
  output logic      [7:0] rx_data,
  output logic            rx_valid
);
  logic [7:0] got_q[$];  // Reply bytes taken
  logic [1:0] pace_q;    // Stall pattern

  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    pace_q   = 2'h0;
  end

  // Slow host is ready one cycle in four
  always @(negedge clk)
  begin
    pace_q   <= pace_q + 2'h1;
    tx_ready <= !slow || (pace_q == 2'h0);
  end

  // Byte taken where ready is seen
  always @(posedge clk)
    if (tx_valid_q && tx_ready)
      got_q.push_back(tx_data_q);

  // One character, four cycles apart; line inverted when idle
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk);
    rx_data  = b;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~b;
    repeat (2) @(negedge clk);
  endtask : send_byte

  // Whole command line
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++)
      send_byte(s[i]);
  endtask : send_line

  // Escape with idle guard before; caller keeps idle after
  task automatic escape();
    repeat (GUARD_CYC + 4) @(negedge clk);
    repeat (3) send_byte(8'h2b);
  endtask : escape
endmodule : mdm_host_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import mdm_pkg::*;
  localparam int unsigned GUARD = 20;
  localparam int unsigned HANG  = 100;

  logic         clk, rstn, clk_en, slow;
  logic [7:0]   rx_data, tx_data_q, pay_data_q, seed;
  logic         rx_valid, tx_valid_q, tx_ready, pay_valid_q;
  logic         urc_event, urc_ack, hangup_done;
  logic         ring, held, data_mode, session;
  logic [3:0]   context_identifier;
  mdm_mode_type mode;
  int           err_count, n_checks, cycles;
  logic [7:0]   exp_q[$];  // Expected payload

  mdm_data_mode_ctrl #(.GUARD_CYC(GUARD), .HANG_CYC(HANG))
  u_mdm_data_mode_ctrl (.clk(clk), .rstn(rstn), .clk_en(clk_en),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .pay_data_q(pay_data_q), .pay_valid_q(pay_valid_q),
    .urc_event(urc_event), .urc_ack(urc_ack),
    .hangup_done(hangup_done), .urc_ring_indicator_q(ring),
    .urc_held_q(held), .data_mode_q(data_mode), .session_q(session),
    .context_identifier_q(context_identifier), .mode_q(mode));

  mdm_host_model #(.GUARD_CYC(GUARD)) u_mdm_host_model (.clk(clk),
    .slow(slow), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Hang guard: run should need about a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // Every payload byte against the model
  always @(posedge clk)
    if (pay_valid_q === 1'b1)
      chk(pay_data_q, exp_q.size() ? exp_q.pop_front() : ~pay_data_q);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Wait for reply end within lim cycles, then compare the text
  task automatic await_reply(input string s, input int lim);
    int n;
    n = 0;
    while (!(mode inside {mode_reply, mode_hang}) && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    while ((mode inside {mode_reply, mode_hang}) && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(8'(u_mdm_host_model.got_q.size()), 8'(s.len()));
    for (int i = 0; i < s.len(); i++)
      chk(u_mdm_host_model.got_q[i], s[i]);
    u_mdm_host_model.got_q.delete();
  endtask : await_reply

  task automatic send_pay(input logic [7:0] b);
    exp_q.push_back(b);
    u_mdm_host_model.send_byte(b);
  endtask : send_pay

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {rstn, slow, urc_event, urc_ack, hangup_done} = 5'h00;
    clk_en = 1'b1;
    seed = 8'd55;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    chk({ring, held, data_mode, session, context_identifier}, 8'h01);
    chk(8'(mode), 8'(mode_cmd));
    // Plain line, unknown line, resume with no session
    u_mdm_host_model.send_line("AT\015");
    await_reply("OK\015\n", 200);
    u_mdm_host_model.send_line("atx\015");
    await_reply("ERROR\015\n", 200);
    u_mdm_host_model.send_line("ATO\015");
    await_reply("ERROR\015\n", 200);
    slow = 1'b1;
    u_mdm_host_model.send_line("AT+CGDATA=\"PPP\",3\015");
    await_reply("CONNECT\015\n", 200);
    chk({data_mode, session, context_identifier}, 8'h33);
    // Random payload, then a command line that must pass as data
    repeat (12)
    begin
      seed = lfsr(seed);
      send_pay(seed == 8'h2b ? 8'h2c : seed);
    end
    send_pay(8'h41);
    send_pay(8'h54);
    send_pay(8'h0d);
    // Unguarded plus, then guarded plus broken by a character
    send_pay(8'h78);
    send_pay(8'h2b);
    repeat (GUARD + 4) @(negedge clk);
    send_pay(8'h2b);
    send_pay(8'h7a);
    // Two unsolicited codes: ring toggles, nothing sent
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk);
      urc_event = 1'b1;
      @(negedge clk);
      urc_event = 1'b0;
      @(negedge clk);
      chk({ring, held}, {i == 0, 1'b1});
    end
    // Frozen clock enable: a code must not toggle the ring line
    @(negedge clk);
    clk_en = 1'b0;
    urc_event = 1'b1;
    @(negedge clk);
    urc_event = 1'b0;
    clk_en = 1'b1;
    @(negedge clk);
    chk({ring, held}, 2'b01);
    chk(8'(u_mdm_host_model.got_q.size()), 8'h00);
    u_mdm_host_model.escape();
    await_reply("OK\015\n", GUARD + 200);
    chk({data_mode, session}, 2'b01);
    u_mdm_host_model.send_line("AT+CGDCONT?\015");
    await_reply("+CGDCONT: 3\015\nOK\015\n", 300);
    @(negedge clk);
    urc_ack = 1'b1;
    @(negedge clk);
    urc_ack = 1'b0;
    @(negedge clk);
    chk(held, 1'b0);
    u_mdm_host_model.send_line("ATO\015");
    await_reply("CONNECT\015\n", 200);
    send_pay(8'h41);
    u_mdm_host_model.escape();
    await_reply("OK\015\n", GUARD + 200);
    u_mdm_host_model.send_line("ATH\015");
    await_reply("OK\015\n", HANG + 60);
    chk(session, 1'b0);
    slow = 1'b0;
    u_mdm_host_model.send_line("ATD*99***5#\015");
    await_reply("CONNECT\015\n", 200);
    chk({data_mode, context_identifier}, 8'h15);
    u_mdm_host_model.escape();
    await_reply("OK\015\n", GUARD + 200);
    u_mdm_host_model.send_line("ATH\015");
    repeat (5) @(negedge clk);
    hangup_done = 1'b1;
    @(negedge clk);
    hangup_done = 1'b0;
    await_reply("OK\015\n", 40);
    chk({session, data_mode}, 2'b00);
    chk(8'(exp_q.size()), 8'h00);
    end_of_test();
  end
endmodule : tb_top
